// [common/ppfs_pkg.sv]
package ppfs_pkg;

    // Register indices on the plain register port.
    localparam logic [3:0] ADDR_PA_DATA   = 4'h0;
    localparam logic [3:0] ADDR_PA_DIR    = 4'h1;
    localparam logic [3:0] ADDR_PA_PULL   = 4'h2;
    localparam logic [3:0] ADDR_PA_WAKE   = 4'h3;
    localparam logic [3:0] ADDR_PB_DATA   = 4'h4;
    localparam logic [3:0] ADDR_PB_DIR    = 4'h5;
    localparam logic [3:0] ADDR_PB_PULL   = 4'h6;
    localparam logic [3:0] ADDR_PA_SEL0   = 4'h7;
    localparam logic [3:0] ADDR_PA_SEL1   = 4'h8;
    localparam logic [3:0] ADDR_PB_SEL0   = 4'h9;
    localparam logic [3:0] ADDR_BIT_OP    = 4'ha;
    localparam logic [3:0] ADDR_POWER     = 4'hb;

    // Reset values.
    localparam logic [7:0] RST_DATA       = 8'hff;
    localparam logic [7:0] RST_DIR        = 8'hff;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // Field positions.
    localparam int         PA3_SEL_LSB    = 6;
    localparam int         PA4_SEL_LSB    = 0;
    localparam int         PB0_SEL_LSB    = 0;
    localparam logic [7:0] SEL_NARROW_MSK = 8'h03;

    // Function select codes.
    localparam logic [1:0] SEL_TIMER      = 2'h1;
    localparam logic [1:0] SEL_SERIAL_CLK = 2'h2;
    localparam logic [1:0] SEL_LVD_IN     = 2'h3;

    // Bit operation write data: [7] set, [6:3] register index, [2:0] bit.
    localparam int         BITOP_SET_POS  = 7;
    localparam int         BITOP_REG_LSB  = 3;
    localparam int         BITOP_BIT_LSB  = 0;

    typedef enum logic [1:0] {
        PPFS_IDLE   = 2'b00,
        PPFS_MODIFY = 2'b01
    } ppfs_bitop_state_t;

endpackage

// [logic/ppfs_wake_detect.sv]
`timescale 1ns/100ps
module ppfs_wake_detect
    import ppfs_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_level,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic [WIDTH-1:0] gpio_mode,
    input  wire logic             powered_down,
    output logic                  wake
);
    typedef struct packed {
        logic [WIDTH-1:0] last;
        logic             wake;
    } ppfs_wake_state_t;

    ppfs_wake_state_t state;
    ppfs_wake_state_t next_state;
    logic [WIDTH-1:0] fall;

    // A falling edge counts only on enabled pins in GPIO mode while powered down.
    always_comb begin
        next_state = state;
        next_state.last = pin_level;
        for (int i = 0; i < WIDTH; i++) begin
            fall[i] = state.last[i] & ~pin_level[i] & enable[i] & gpio_mode[i];
        end
        next_state.wake = powered_down & (|fall);
    end

    // Last level starts high, so a pin already low at reset reads as a falling edge in the first cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '{last: '1, wake: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign wake = state.wake;
endmodule

// [logic/ppfs_port_mux.sv]
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
module ppfs_port_mux
    import ppfs_pkg::*;
#(
    parameter int PA_WIDTH = 8,
    parameter int PB_WIDTH = 4
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic [3:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [7:0]          reg_rdata,
    input  wire logic [PA_WIDTH-1:0] pa_pad_in,
    output logic      [PA_WIDTH-1:0] pa_pad_out,
    output logic      [PA_WIDTH-1:0] pa_pad_oe,
    output logic      [PA_WIDTH-1:0] pa_pull_on,
    input  wire logic [PB_WIDTH-1:0] pb_pad_in,
    output logic      [PB_WIDTH-1:0] pb_pad_out,
    output logic      [PB_WIDTH-1:0] pb_pad_oe,
    output logic      [PB_WIDTH-1:0] pb_pull_on,
    input  wire logic                timer_primary_output,
    input  wire logic                timer_complement_output,
    input  wire logic                serial_clk_out,
    input  wire logic                serial_clk_oe,
    output logic                     serial_clk_in,
    output logic                     low_voltage_detect_input,
    output logic                     lvd_in_selected,
    input  wire logic                sleep_request,
    output logic                     wake_up
);
    typedef struct packed {
        logic [PA_WIDTH-1:0] pa_data;
        logic [PA_WIDTH-1:0] pa_dir;
        logic [PA_WIDTH-1:0] pa_pull;
        logic [PA_WIDTH-1:0] pa_wake;
        logic [PB_WIDTH-1:0] pb_data;
        logic [PB_WIDTH-1:0] pb_dir;
        logic [PB_WIDTH-1:0] pb_pull;
        logic [7:0]          porta_low_pin_select;
        logic [1:0]          porta_pin4_select;
        logic [1:0]          portb_pin0_select;
        logic                powered_down;
        ppfs_bitop_state_t   bitop;
        logic [3:0]          bitop_reg;
        logic [2:0]          bitop_bit;
        logic                bitop_set;
        logic [7:0]          bitop_byte;
        logic [7:0]          rdata;
        logic [PA_WIDTH-1:0] pa_out;
        logic [PA_WIDTH-1:0] pa_oe;
        logic [PA_WIDTH-1:0] pa_pu;
        logic [PB_WIDTH-1:0] pb_out;
        logic [PB_WIDTH-1:0] pb_oe;
        logic [PB_WIDTH-1:0] pb_pu;
        logic                sck_in;
        logic                lvd_in;
        logic                lvd_sel;
    } ppfs_state_t;

    ppfs_state_t         state;
    ppfs_state_t         next_state;
    logic [1:0]          pin3_select_field;
    logic [1:0]          pin4_select_field;
    logic [1:0]          pb_pin0_select_field;
    logic [PA_WIDTH-1:0] pa_gpio;
    logic                wake_pulse;

    // Read value of any register; port data reads follow direction.
    function automatic logic [7:0] read_reg(input ppfs_state_t s, input logic [3:0] a,
                                            input logic [PA_WIDTH-1:0] pa_in,
                                            input logic [PB_WIDTH-1:0] pb_in);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_PA_DATA: v = 8'((s.pa_dir & pa_in) | (~s.pa_dir & s.pa_data));
            ADDR_PA_DIR:  v = 8'(s.pa_dir);
            ADDR_PA_PULL: v = 8'(s.pa_pull);
            ADDR_PA_WAKE: v = 8'(s.pa_wake);
            ADDR_PB_DATA: v = 8'((s.pb_dir & pb_in) | (~s.pb_dir & s.pb_data));
            ADDR_PB_DIR:  v = 8'(s.pb_dir);
            ADDR_PB_PULL: v = 8'(s.pb_pull);
            ADDR_PA_SEL0: v = s.porta_low_pin_select;
            ADDR_PA_SEL1: v = 8'(s.porta_pin4_select) & SEL_NARROW_MSK;
            ADDR_PB_SEL0: v = 8'(s.portb_pin0_select) & SEL_NARROW_MSK;
            ADDR_POWER:   v = {7'h00, s.powered_down};
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    // Byte write into any writable register.
    function automatic ppfs_state_t write_reg(input ppfs_state_t s, input logic [3:0] a,
                                              input logic [7:0] d);
        ppfs_state_t n;
        n = s;
        case (a)
            ADDR_PA_DATA: n.pa_data = d[PA_WIDTH-1:0];
            ADDR_PA_DIR:  n.pa_dir  = d[PA_WIDTH-1:0];
            ADDR_PA_PULL: n.pa_pull = d[PA_WIDTH-1:0];
            ADDR_PA_WAKE: n.pa_wake = d[PA_WIDTH-1:0];
            ADDR_PB_DATA: n.pb_data = d[PB_WIDTH-1:0];
            ADDR_PB_DIR:  n.pb_dir  = d[PB_WIDTH-1:0];
            ADDR_PB_PULL: n.pb_pull = d[PB_WIDTH-1:0];
            ADDR_PA_SEL0: n.porta_low_pin_select = d;
            ADDR_PA_SEL1: n.porta_pin4_select = d[1:0];
            ADDR_PB_SEL0: n.portb_pin0_select = d[1:0];
            ADDR_POWER:   n.powered_down = d[0];
            default:      n = s;
        endcase
        return n;
    endfunction

    assign pin3_select_field    = state.porta_low_pin_select[PA3_SEL_LSB +: 2];
    assign pin4_select_field    = state.porta_pin4_select[PA4_SEL_LSB +: 2];
    assign pb_pin0_select_field = state.portb_pin0_select[PB0_SEL_LSB +: 2];

    // Port A pins that are not claimed by the timer stay GPIO for wake-up.
    always_comb begin
        pa_gpio    = '1;
        pa_gpio[3] = (pin3_select_field != SEL_TIMER);
        pa_gpio[4] = (pin4_select_field != SEL_TIMER);
    end

    // Register access, bit operations and pad muxing.
    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        if (reg_read) begin
            next_state.rdata = read_reg(state, reg_addr, pa_pad_in, pb_pad_in);
        end
        case (state.bitop)
            PPFS_IDLE: begin
                if (reg_write && reg_addr == ADDR_BIT_OP) begin
                    // Bit ops take two cycles; a byte write landing in the second is dropped.
                    next_state.bitop      = PPFS_MODIFY;
                    next_state.bitop_set  = reg_wdata[BITOP_SET_POS];
                    next_state.bitop_reg  = reg_wdata[BITOP_REG_LSB +: 4];
                    next_state.bitop_bit  = reg_wdata[BITOP_BIT_LSB +: 3];
                    next_state.bitop_byte = read_reg(state, reg_wdata[BITOP_REG_LSB +: 4],
                                                     pa_pad_in, pb_pad_in);
                end else if (reg_write) begin
                    next_state = write_reg(next_state, reg_addr, reg_wdata);
                end
            end
            PPFS_MODIFY: begin
                next_state.bitop = PPFS_IDLE;
                next_state.bitop_byte[state.bitop_bit] = state.bitop_set;
                next_state = write_reg(next_state, state.bitop_reg, next_state.bitop_byte);
            end
            default: next_state.bitop = PPFS_IDLE;
        endcase

        // GPIO by default: latch drives the pad while direction is zero.
        next_state.pa_out = state.pa_data;
        next_state.pa_oe  = ~state.pa_dir;
        next_state.pb_out = state.pb_data;
        next_state.pb_oe  = ~state.pb_dir;
        if (pin3_select_field == SEL_TIMER) begin
            next_state.pa_out[3] = timer_primary_output;
            next_state.pa_oe[3]  = 1'b1;
        end
        if (pin4_select_field == SEL_TIMER) begin
            next_state.pa_out[4] = timer_complement_output;
            next_state.pa_oe[4]  = 1'b1;
        end
        next_state.lvd_sel = (pb_pin0_select_field == SEL_LVD_IN);
        next_state.sck_in  = pb_pad_in[0] & (pb_pin0_select_field == SEL_SERIAL_CLK);
        next_state.lvd_in  = pb_pad_in[0] & next_state.lvd_sel;
        if (pb_pin0_select_field == SEL_SERIAL_CLK) begin
            next_state.pb_out[0] = serial_clk_out;
            next_state.pb_oe[0]  = serial_clk_oe;
        end else if (pb_pin0_select_field == SEL_LVD_IN) begin
            next_state.pb_oe[0]  = 1'b0;
        end
        // Pull-high only where the pad is not being driven.
        next_state.pa_pu = state.pa_pull & ~next_state.pa_oe;
        next_state.pb_pu = state.pb_pull & ~next_state.pb_oe;
        if (wake_pulse) begin
            next_state.powered_down = 1'b0;
        end else if (sleep_request) begin
            next_state.powered_down = 1'b1;
        end
    end

    // Reset puts every pin to input with latches high.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state         <= '0;
            state.pa_data <= RST_DATA[PA_WIDTH-1:0];
            state.pa_dir  <= RST_DIR[PA_WIDTH-1:0];
            state.pb_data <= RST_DATA[PB_WIDTH-1:0];
            state.pb_dir  <= RST_DIR[PB_WIDTH-1:0];
            state.pa_wake <= RST_ZERO[PA_WIDTH-1:0];
            // Pads idle at the latch reset level, so a later direction flip shows high at once.
            state.pa_out  <= RST_DATA[PA_WIDTH-1:0];
            state.pb_out  <= RST_DATA[PB_WIDTH-1:0];
            state.bitop   <= PPFS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ppfs_wake_detect #(
        .WIDTH(PA_WIDTH)
    ) u_wake (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .pin_level    (pa_pad_in),
        .enable       (state.pa_wake),
        .gpio_mode    (pa_gpio),
        .powered_down (state.powered_down),
        .wake         (wake_pulse)
    );

    assign reg_rdata                = state.rdata;
    assign pa_pad_out               = state.pa_out;
    assign pa_pad_oe                = state.pa_oe;
    assign pa_pull_on               = state.pa_pu;
    assign pb_pad_out               = state.pb_out;
    assign pb_pad_oe                = state.pb_oe;
    assign pb_pull_on               = state.pb_pu;
    assign serial_clk_in            = state.sck_in;
    assign low_voltage_detect_input = state.lvd_in;
    assign lvd_in_selected          = state.lvd_sel;
    assign wake_up                  = wake_pulse;
endmodule

// [test/ppfs_port_mux_assertions.sv]
`timescale 1ns/100ps
// Watches the port mux from its pins only; each property but a_wake_single ties an output to its cause.
module ppfs_port_mux_chk
    import ppfs_pkg::*;
#(
    parameter int PA_WIDTH = 8,
    parameter int PB_WIDTH = 4
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic [3:0]          reg_addr,
    input wire logic                reg_read,
    input wire logic [7:0]          reg_rdata,
    input wire logic [PA_WIDTH-1:0] pa_pad_in,
    input wire logic [PA_WIDTH-1:0] pa_pad_out,
    input wire logic [PA_WIDTH-1:0] pa_pad_oe,
    input wire logic [PA_WIDTH-1:0] pa_pull_on,
    input wire logic [PB_WIDTH-1:0] pb_pad_in,
    input wire logic [PB_WIDTH-1:0] pb_pad_oe,
    input wire logic [PB_WIDTH-1:0] pb_pull_on,
    input wire logic                low_voltage_detect_input,
    input wire logic                lvd_in_selected,
    input wire logic                wake_up
);
    logic [PA_WIDTH-1:0] pa_prev;
    logic                fall_seen;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Remembers a Port A falling edge so that every wake pulse can be traced to one.
    always_ff @(posedge clk) begin
        pa_prev   <= pa_pad_in;
        fall_seen <= |(pa_prev & ~pa_pad_in);
    end

    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_sel_upper_zero: assert property (reg_read && (reg_addr == ADDR_PA_SEL1 || reg_addr == ADDR_PB_SEL0)
        |=> reg_rdata[7:2] == 6'h00) else $error("unimplemented select bits read nonzero");
    a_reset_pads: assert property ($past(sys_rst) |-> pa_pad_oe == '0 && pa_pad_out == '1)
        else $error("pads not released high after reset");
    a_pull_gated: assert property ((pa_pull_on & pa_pad_oe) == '0 && (pb_pull_on & pb_pad_oe) == '0)
        else $error("pull-high active on a driven pin");
    a_lvd_no_drive: assert property (lvd_in_selected |-> !pb_pad_oe[0])
        else $error("detector input pin is driven");
    a_lvd_follows: assert property (low_voltage_detect_input == (lvd_in_selected && $past(pb_pad_in[0])))
        else $error("detector input does not follow the pin");
    a_wake_single: assert property (wake_up |=> !wake_up)
        else $error("wake pulse longer than one cycle");
    a_wake_cause: assert property (wake_up |-> fall_seen || $past(fall_seen) || $past(fall_seen, 2))
        else $error("wake pulse without a falling edge");

    cover property (wake_up);
    cover property (lvd_in_selected && low_voltage_detect_input);
    cover property (&pa_pad_oe);
endmodule

bind ppfs_port_mux ppfs_port_mux_chk #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pa_pad_in(pa_pad_in), .pa_pad_out(pa_pad_out), .pa_pad_oe(pa_pad_oe), .pa_pull_on(pa_pull_on),
    .pb_pad_in(pb_pad_in), .pb_pad_oe(pb_pad_oe), .pb_pull_on(pb_pull_on),
    .low_voltage_detect_input(low_voltage_detect_input), .lvd_in_selected(lvd_in_selected),
    .wake_up(wake_up));

// [test/ppfs_periph_model.sv]
`timescale 1ns/100ps
// Stands in for the timer and serial peripherals.
module ppfs_periph_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic enable,
    output logic      tmr_p,
    output logic      tmr_n,
    output logic      sck_out,
    output logic      sck_oe
);
    // Timer outputs and sck_out toggle every cycle while enabled, so a misrouted pin shows a moving level.
    always_ff @(posedge clk) begin
        if (sys_rst || !enable) begin
            tmr_p   <= 1'b0;
            sck_out <= 1'b0;
        end else begin
            tmr_p   <= ~tmr_p;
            sck_out <= ~sck_out;
        end
    end
    assign tmr_n  = ~tmr_p;
    assign sck_oe = enable;
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import ppfs_pkg::*;
    logic       clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, sleep_request = 1'b0, pen = 1'b0;
    logic [3:0] reg_addr = 4'h0, pb_pad_in = 4'h0, pb_pad_out, pb_pad_oe, pb_pull_on;
    logic [7:0] reg_wdata = 8'h00, pa_pad_in = 8'hff, reg_rdata, pa_pad_out, pa_pad_oe, pa_pull_on;
    logic       tmr_p, tmr_n, sck_out, sck_oe, sck_in, lvd_in, lvd_sel, wake_up;
    int         n_errors = 0;
    int         cmp_count = 0;

    ppfs_port_mux uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pa_pad_in(pa_pad_in),
        .pa_pad_out(pa_pad_out), .pa_pad_oe(pa_pad_oe), .pa_pull_on(pa_pull_on), .pb_pad_in(pb_pad_in),
        .pb_pad_out(pb_pad_out), .pb_pad_oe(pb_pad_oe), .pb_pull_on(pb_pull_on),
        .timer_primary_output(tmr_p), .timer_complement_output(tmr_n), .serial_clk_out(sck_out),
        .serial_clk_oe(sck_oe), .serial_clk_in(sck_in), .low_voltage_detect_input(lvd_in),
        .lvd_in_selected(lvd_sel), .sleep_request(sleep_request), .wake_up(wake_up));
    ppfs_periph_model u_per (.clk(clk), .sys_rst(sys_rst), .enable(pen), .tmr_p(tmr_p), .tmr_n(tmr_n),
        .sck_out(sck_out), .sck_oe(sck_oe));

    // The clock runs at 20 MHz.
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    // Strobes last one cycle; read data is taken in the cycle after the strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic t_reset();
        rd(ADDR_PA_DIR, RST_DIR);
        rd(ADDR_PB_DIR, 8'h0f);
        rd(ADDR_PA_WAKE, RST_ZERO);
        rd(ADDR_PA_SEL0, RST_ZERO);
        rd(4'hc, RST_ZERO);
        chk(pa_pad_oe, RST_ZERO);
        chk(pa_pad_out, RST_DATA);
        chk({4'h0, pb_pad_out}, 8'h0f);
    endtask

    // Turning pins to outputs without a data write must drive the reset latch value.
    task automatic t_out_high();
        @(posedge clk) pa_pad_in <= 8'h00;
        wr(ADDR_PA_DIR, 8'h00);
        rd(ADDR_PA_DATA, RST_DATA);
        chk(pa_pad_oe, 8'hff);
        chk(pa_pad_out, 8'hff);
        wr(ADDR_PA_DIR, 8'hff);
        @(posedge clk) pa_pad_in <= 8'h5a;
        rd(ADDR_PA_DATA, 8'h5a);
    endtask

    // Every code of the three select fields, with the peripherals running in all of them.
    task automatic t_sel();
        logic [1:0] c;
        logic       t, s, l, v1, v2, so, soe, pb;
        wr(ADDR_PA_PULL, 8'hff);
        wr(ADDR_PB_PULL, 8'h0f);
        @(posedge clk) pb_pad_in <= 4'h5;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            t = (c == SEL_TIMER);
            s = (c == SEL_SERIAL_CLK);
            l = (c == SEL_LVD_IN);
            @(posedge clk) pen <= 1'b0;
            wr(ADDR_PA_SEL0, {c, 6'h00});
            wr(ADDR_PA_SEL1, {6'h3f, c});
            wr(ADDR_PB_SEL0, {6'h3f, c});
            rd(ADDR_PA_SEL1, {6'h00, c});
            rd(ADDR_PB_SEL0, {6'h00, c});
            @(posedge clk) pen <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            v1 = tmr_p;
            v2 = tmr_n;
            so = sck_out;
            soe = sck_oe;
            pb = pb_pad_in[0];
            @(posedge clk);
            #1 chk({pa_pad_out[3], pa_pad_oe[3], pa_pad_out[4], pa_pad_oe[4], pb_pad_out[0] & !l, pb_pad_oe[0],
                    sck_in, lvd_in}, {t ? v1 : 1'b1, t, t ? v2 : 1'b1, t, s ? so : !l, s && soe, s && pb,
                    l && pb});
            chk({lvd_sel, pa_pull_on[3], pa_pull_on[4], pb_pull_on[0], 4'h0}, {l, !t, !t, !(s && soe), 4'h0});
        end
        @(posedge clk) pen <= 1'b0;
    endtask

    // Single-bit operations copy input pin levels into the latch along with the target bit.
    task automatic t_bitop();
        wr(ADDR_PA_DATA, 8'h0f);
        wr(ADDR_PA_DIR, 8'hf0);
        @(posedge clk) pa_pad_in <= 8'ha5;
        wr(ADDR_BIT_OP, 8'h02);
        wr(ADDR_BIT_OP, 8'h0f);
        rd(ADDR_PA_DIR, 8'h70);
        wr(ADDR_PA_DIR, 8'h00);
        rd(ADDR_PA_DATA, 8'hab);
    endtask

    task automatic fall(input logic [7:0] lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk) pa_pad_in <= 8'hff;
        repeat (2) @(posedge clk);
        pa_pad_in <= lvl;
        repeat (4) begin
            @(posedge clk);
            #1 seen = seen | wake_up;
        end
        chk({7'h00, seen}, {7'h00, exp});
    endtask

    // Wake needs power-down, an enabled bit and a pin left as general purpose I/O.
    task automatic t_wake();
        wr(ADDR_PA_DIR, 8'hff);
        wr(ADDR_PA_SEL0, {SEL_TIMER, 6'h00});
        wr(ADDR_BIT_OP, 8'h99);
        wr(ADDR_BIT_OP, 8'h9b);
        rd(ADDR_PA_WAKE, 8'h0a);
        fall(8'hfd, 1'b0);
        @(posedge clk) sleep_request <= 1'b1;
        @(posedge clk) sleep_request <= 1'b0;
        fall(8'hf7, 1'b0);
        fall(8'hfb, 1'b0);
        fall(8'hfd, 1'b1);
        rd(ADDR_POWER, 8'h00);
        wr(ADDR_POWER, 8'h01);
        fall(8'hf5, 1'b1);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_out_high();
        t_sel();
        t_bitop();
        t_wake();
        test_done();
    end

    // A hang is cut short well beyond the roughly 160 cycles the tests need.
    initial begin
        #(50 * 4000);
        n_errors++;
        test_done();
    end
endmodule
